// ---- verilog/ulc_uart.sv ----
// Purpose: Serial port with line control, divisor latch and register map.
// Assumes: Classic Wishbone slave, byte data in lane 0, one 50 MHz clock.
// Notes:   No FIFO; the block always runs in compatibility mode.
//
// Functional notes
// - Select bit one maps offsets to divisor.
// - Select bit zero maps buffers and enables.
// - Silence bit drives infrared output low only.
// - Stick parity sends and checks fixed bit.
// - Even select gives even count of ones.
// - Parity bit sits after last data bit.
// - Stop select gives one, one and a half or two.
// - Word length bits pick five to eight.
// - Bit zero travels first on line.
// - Compatibility mode reads FIFO bits as zero.
// - Divisor 1..65535 gives sixteen-times tick.
// - Frame is start, data, parity, stop.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "ulc_params.svh"

module ulc_uart
  import ulc_pkg::*;
(
  input  wire logic            clock_i,                    // 50 MHz clock
  input  wire logic            reset_n_i,                  // Sync reset, low
  input  wire ulc_wb_req_type  wb_req_i,                   // Bus request
  output logic                 wb_ack_o,                   // Bus acknowledge
  output logic [31:0]          wb_dat_o,                   // Bus read data
  input  wire logic            serial_input_i,             // Line input pin
  output logic                 serial_output_o,            // Line output
  output logic                 infrared_transmit_output_o, // Infrared output
  output logic                 rts_n_o,                    // Request to send
  output logic                 dtr_n_o,                    // Terminal ready
  output logic                 irq_o                       // Interrupt level
);
  ulc_regs_type r_reg;
  ulc_regs_type r_next;
  logic         req;
  logic         wr;
  logic         dl;
  logic         rx_in;
  logic [2:0]   last;
  logic [5:0]   stop_end;
  logic [7:0]   msk;
  logic [3:0]   ev;
  logic         pend;
  logic [1:0]   iid;
  logic [7:0]   lstat;

  // ------------------------------------------------------------
  // Decode and frame format
  // ------------------------------------------------------------
  assign req = wb_req_i.cyc & wb_req_i.stb & ~r_reg.ack;
  assign wr = req & wb_req_i.we & wb_req_i.sel[0];
  assign dl = r_reg.lctl[`ULC_LC_DLS];
  assign rx_in = r_reg.mctl[`ULC_MC_LOOP] ? r_reg.txo : r_reg.rsync[1];
  assign last = 3'd4 + {1'b0, r_reg.lctl[1:0]};
  assign msk = 8'hFF >> (2'd3 - r_reg.lctl[1:0]);
  assign stop_end = !r_reg.lctl[`ULC_LC_STOP] ? `ULC_BIT_END :
                    (r_reg.lctl[1:0] == 2'b00) ? `ULC_STOP15_END : `ULC_STOP2_END;
  assign lstat = {1'b0, ~r_reg.thr_full & (r_reg.txs == SER_IDLE),
                  ~r_reg.thr_full, r_reg.sb, r_reg.fe, r_reg.pe, r_reg.oe, r_reg.dr};

  // Identity follows live conditions, highest priority first.
  always_comb
  begin
    pend = 1'b1;
    iid = 2'b00;
    if (r_reg.ien[2] & (r_reg.oe | r_reg.pe | r_reg.fe | r_reg.sb))
      iid = 2'b11;
    else if (r_reg.ien[0] & r_reg.dr)
      iid = 2'b10;
    else if (r_reg.ien[1] & ~r_reg.thr_full)
      iid = 2'b01;
    else
      pend = 1'b0;
  end

  // Parity bit for a data parity x.
  function automatic logic pbit(input logic x, input logic [7:0] lc);
    pbit = lc[`ULC_LC_STICK] ? ~lc[`ULC_LC_EVEN] :
           (x ^ ~lc[`ULC_LC_EVEN]);
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    r_next = r_reg;
    ev = 4'h0;
    // Baud tick; a zero divisor halts the serial engines.
    r_next.tick = 1'b0;
    if (r_reg.div != 16'h0000)
    begin
      if (r_reg.bcnt >= r_reg.div - 16'h0001)
      begin
        r_next.bcnt = 16'h0000;
        r_next.tick = 1'b1;
      end
      else
      begin
        r_next.bcnt = r_reg.bcnt + 16'h0001;
      end
    end

    // Transmitter runs before the bus so that a new write is not lost.
    if (r_reg.tick)
      r_next.txc = r_reg.txc + 6'd1;
    unique case (r_reg.txs)
      SER_IDLE:
      begin
        r_next.txo = 1'b1;
        r_next.txc = 6'd0;
        if (r_reg.thr_full && r_reg.tick)
        begin
          r_next.txsh = r_reg.thr;
          r_next.txp = ^(r_reg.thr & msk);
          r_next.thr_full = 1'b0;
          ev[1] = 1'b1;
          r_next.txs = SER_START;
          r_next.txo = 1'b0;
        end
      end
      SER_START:
      begin
        if (r_reg.tick && r_reg.txc == `ULC_BIT_END)
        begin
          r_next.txc = 6'd0;
          r_next.txb = 3'd0;
          r_next.txs = SER_DATA;
          r_next.txo = r_reg.txsh[0];
        end
      end
      SER_DATA:
      begin
        if (r_reg.tick && r_reg.txc == `ULC_BIT_END)
        begin
          r_next.txc = 6'd0;
          if (r_reg.txb == last)
          begin
            if (r_reg.lctl[`ULC_LC_PEN])
            begin
              r_next.txs = SER_PAR;
              r_next.txo = pbit(r_reg.txp, r_reg.lctl);
            end
            else
            begin
              r_next.txs = SER_STOP;
              r_next.txo = 1'b1;
            end
          end
          else
          begin
            r_next.txb = r_reg.txb + 3'd1;
            r_next.txsh = r_reg.txsh >> 1;
            r_next.txo = r_reg.txsh[1];
          end
        end
      end
      SER_PAR:
      begin
        if (r_reg.tick && r_reg.txc == `ULC_BIT_END)
        begin
          r_next.txc = 6'd0;
          r_next.txs = SER_STOP;
          r_next.txo = 1'b1;
        end
      end
      SER_STOP:
      begin
        if (r_reg.tick && r_reg.txc == stop_end)
        begin
          r_next.txc = 6'd0;
          r_next.txs = SER_IDLE;
        end
      end
      default: r_next.txs = SER_IDLE;
    endcase

    // Bus: ack one cycle after the request, read data with it.
    r_next.ack = req;
    if (req && !wb_req_i.we)
    begin
      r_next.rd = 32'h0000_0000;
      case (wb_req_i.adr)
        `ULC_IDX_BUF:
        begin
          r_next.rd[7:0] = dl ? r_reg.div[7:0] : r_reg.receive_buffer;
          r_next.dr = dl & r_reg.dr;
        end
        `ULC_IDX_IEN:    r_next.rd[7:0] = dl ? r_reg.div[15:8] : {4'h0, r_reg.ien};
        `ULC_IDX_IID:    r_next.rd[7:0] = {4'h0, 1'b0, iid, ~pend};
        `ULC_IDX_LCTL:   r_next.rd[7:0] = r_reg.lctl;
        `ULC_IDX_MCTL:   r_next.rd[7:0] = {3'h0, r_reg.mctl};
        `ULC_IDX_LSTAT:
        begin
          r_next.rd[7:0] = lstat;
          r_next.oe = 1'b0;
          r_next.pe = 1'b0;
          r_next.fe = 1'b0;
          r_next.sb = 1'b0;
        end
        `ULC_IDX_MSTAT:
          if (r_reg.mctl[`ULC_MC_LOOP])
            r_next.rd[7:4] = {r_reg.mctl[3], r_reg.mctl[2], r_reg.mctl[0], r_reg.mctl[1]};
        `ULC_IDX_SCR:    r_next.rd[7:0] = r_reg.scr;
        `ULC_IDX_EVSTAT: r_next.rd[3:0] = r_reg.evs;
        default:         r_next.rd = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      case (wb_req_i.adr)
        `ULC_IDX_BUF:
          if (dl)
            r_next.div[7:0] = wb_req_i.dat[7:0];
          else
          begin
            r_next.thr = wb_req_i.dat[7:0];
            r_next.thr_full = 1'b1;
          end
        `ULC_IDX_IEN:
          if (dl)
            r_next.div[15:8] = wb_req_i.dat[7:0];
          else
            r_next.ien = wb_req_i.dat[3:0];
        `ULC_IDX_LCTL:   r_next.lctl = wb_req_i.dat[7:0];
        `ULC_IDX_MCTL:   r_next.mctl = wb_req_i.dat[4:0];
        `ULC_IDX_SCR:    r_next.scr = wb_req_i.dat[7:0];
        `ULC_IDX_EVCLR:  r_next.evs = r_reg.evs & ~wb_req_i.dat[3:0];
        default:         r_next.scr = r_next.scr;
      endcase
    end

    // Receiver runs after the bus so that new status wins over a read.
    r_next.rsync = {r_reg.rsync[0], serial_input_i};
    r_next.rprev = rx_in;
    if (r_reg.tick)
      r_next.rxc = r_reg.rxc + 6'd1;
    unique case (r_reg.rxs)
      SER_IDLE:
      begin
        r_next.rxc = 6'd0;
        if (r_reg.rprev && !rx_in)
          r_next.rxs = SER_START;
      end
      SER_START:
      begin
        if (r_reg.tick && r_reg.rxc == `ULC_MID_TICK)
        begin
          r_next.rxc = 6'd0;
          r_next.rxb = 3'd0;
          r_next.rxp = 1'b0;
          r_next.rpe = 1'b0;
          r_next.rfe = 1'b0;
          r_next.rzero = 1'b1;
          r_next.rxs = rx_in ? SER_IDLE : SER_DATA;
        end
      end
      SER_DATA:
      begin
        if (r_reg.tick && r_reg.rxc == `ULC_BIT_END)
        begin
          r_next.rxc = 6'd0;
          r_next.rxsh = {rx_in, r_reg.rxsh[7:1]};
          r_next.rxp = r_reg.rxp ^ rx_in;
          r_next.rzero = r_reg.rzero & ~rx_in;
          r_next.rxb = r_reg.rxb + 3'd1;
          if (r_reg.rxb == last)
            r_next.rxs = r_reg.lctl[`ULC_LC_PEN] ? SER_PAR : SER_STOP;
        end
      end
      SER_PAR:
      begin
        if (r_reg.tick && r_reg.rxc == `ULC_BIT_END)
        begin
          r_next.rxc = 6'd0;
          r_next.rpe = rx_in != pbit(r_reg.rxp, r_reg.lctl);
          r_next.rzero = r_reg.rzero & ~rx_in;
          r_next.rxs = SER_STOP;
        end
      end
      SER_STOP:
      begin
        if (r_reg.tick && (r_reg.rxc == `ULC_BIT_END || r_reg.rxc == stop_end))
          r_next.rfe = r_reg.rfe | ~rx_in;
        if (r_reg.tick && r_reg.rxc == stop_end)
        begin
          r_next.rxs = SER_IDLE;
          r_next.receive_buffer = r_reg.rxsh >> (2'd3 - r_reg.lctl[1:0]);
          r_next.dr = 1'b1;
          r_next.oe = r_next.oe | r_reg.dr;
          r_next.pe = r_next.pe | r_reg.rpe;
          r_next.fe = r_next.fe | r_reg.rfe | ~rx_in;
          r_next.sb = r_next.sb | (r_reg.rzero & ~rx_in);
          ev[0] = 1'b1;
          ev[2] = r_reg.dr | r_reg.rpe | r_reg.rfe | ~rx_in;
        end
      end
      default: r_next.rxs = SER_IDLE;
    endcase

    // Events are sticky and a new event wins over a clear.
    r_next.evs = r_next.evs | ev;
    r_next.irq = |(r_next.evs & r_next.ien);
    r_next.serial_output = r_next.mctl[`ULC_MC_LOOP] | r_next.txo;
    r_next.iro = ~r_next.lctl[`ULC_LC_SIL] & r_next.txo;
  end

  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      r_reg <= '0;
      r_reg.div <= `ULC_DIV_RST;
      r_reg.lctl <= `ULC_LCTL_RST;
      r_reg.txs <= SER_IDLE;
      r_reg.rxs <= SER_IDLE;
      r_reg.txo <= 1'b1;
      r_reg.serial_output <= 1'b1;
      r_reg.iro <= 1'b1;
      r_reg.rsync <= 2'b11;
      r_reg.rprev <= 1'b1;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.ack;
  assign wb_dat_o = r_reg.rd;
  assign serial_output_o = r_reg.serial_output;
  assign infrared_transmit_output_o = r_reg.iro;
  assign rts_n_o = ~r_reg.mctl[1] | r_reg.mctl[`ULC_MC_LOOP];
  assign dtr_n_o = ~r_reg.mctl[0] | r_reg.mctl[`ULC_MC_LOOP];
  assign irq_o = r_reg.irq;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  a_div_low_map: assert property (
    (wr && dl && wb_req_i.adr == `ULC_IDX_BUF) |=> r_reg.div[7:0] == $past(wb_req_i.dat[7:0]))
    else $error("divisor low byte not written");
  a_ien_read: assert property (
    (wb_ack_o && !wb_req_i.we && !dl && wb_req_i.adr == `ULC_IDX_IEN)
    |-> wb_dat_o[7:0] == {4'h0, r_reg.ien})
    else $error("enable register read wrong");
  a_thr_write: assert property (
    (wr && !dl && wb_req_i.adr == `ULC_IDX_BUF) |=> r_reg.thr_full)
    else $error("transmit buffer not loaded");
  a_ir_silent: assert property (
    ($past(r_reg.lctl[`ULC_LC_SIL]) && r_reg.lctl[`ULC_LC_SIL])
    |-> !infrared_transmit_output_o && serial_output_o == (r_reg.txo | r_reg.mctl[4]))
    else $error("silence handling wrong");
  a_stick_par: assert property (
    (r_reg.txs == SER_PAR && r_reg.lctl[5] && $stable(r_reg.lctl))
    |-> r_reg.txo == ~r_reg.lctl[4])
    else $error("stick parity bit wrong");
  a_even_par: assert property (
    (r_reg.txs == SER_PAR && !r_reg.lctl[5] && $stable(r_reg.lctl))
    |-> (r_reg.txo ^ r_reg.txp) == ~r_reg.lctl[4])
    else $error("parity count wrong");
  a_par_place: assert property (
    $rose(r_reg.txs == SER_PAR) |-> $past(r_reg.txs) == SER_DATA && r_reg.lctl[3])
    else $error("parity bit out of place");
  a_stop_len: assert property (
    $fell(r_reg.txs == SER_STOP) |-> $past(r_reg.txc) == $past(stop_end))
    else $error("stop length wrong");
  a_word_len: assert property (
    ($past(r_reg.txs) == SER_DATA && r_reg.txs != SER_DATA) |-> $past(r_reg.txb) == $past(last))
    else $error("word length wrong");
  a_lsb_first: assert property (
    $rose(r_reg.txs == SER_DATA) |-> r_reg.txo == r_reg.txsh[0] && r_reg.txb == 3'd0)
    else $error("first data bit not bit zero");
  a_compat_zero: assert property (
    (wb_ack_o && !wb_req_i.we && wb_req_i.adr == `ULC_IDX_IID)
    |-> wb_dat_o[7:6] == 2'b00 && wb_dat_o[3] == 1'b0)
    else $error("FIFO bits not zero");
  a_tick_rate: assert property (
    (r_reg.tick && r_reg.div == 16'h0003 && $stable(r_reg.div)) |=> !r_reg.tick ##1 !r_reg.tick)
    else $error("baud tick too early");
  a_start_bit: assert property (
    $rose(r_reg.txs == SER_START) |-> !r_reg.txo [*8])
    else $error("start bit not low");
endmodule
`default_nettype wire

// ---- verilog/ulc_params.svh ----
// Purpose: Register indices, field positions, reset values and timing counts.
// Assumes: Included by the line-control block and its package users.
// Notes:   Byte address of a register is four times its index.
`ifndef ULC_PARAMS_SVH
`define ULC_PARAMS_SVH
// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define ULC_IDX_BUF    4'h0
`define ULC_IDX_IEN    4'h1
`define ULC_IDX_IID    4'h2
`define ULC_IDX_LCTL   4'h3
`define ULC_IDX_MCTL   4'h4
`define ULC_IDX_LSTAT  4'h5
`define ULC_IDX_MSTAT  4'h6
`define ULC_IDX_SCR    4'h7
`define ULC_IDX_EVSTAT 4'h8
`define ULC_IDX_EVCLR  4'h9
// ------------------------------------------------------------
// Line and modem control fields and reset values
// ------------------------------------------------------------
`define ULC_LC_DLS     7
`define ULC_LC_SIL     6
`define ULC_LC_STICK   5
`define ULC_LC_EVEN    4
`define ULC_LC_PEN     3
`define ULC_LC_STOP    2
`define ULC_MC_LOOP    4
`define ULC_LCTL_RST   8'h00
`define ULC_DIV_RST    16'h0000
// ------------------------------------------------------------
// Timing in ticks of the sixteen-times clock
// ------------------------------------------------------------
`define ULC_BIT_END    6'h0F
`define ULC_MID_TICK   6'h07
`define ULC_STOP15_END 6'h17
`define ULC_STOP2_END  6'h1F
`endif

// ---- verilog/ulc_pkg.sv ----
// Purpose: Types shared by the line-control block.
// Assumes: Nothing beyond standard SystemVerilog.
// Notes:   All state of the block lives in one packed struct.
package ulc_pkg;
  typedef enum logic [4:0] {
    SER_IDLE  = 5'b00001,
    SER_START = 5'b00010,
    SER_DATA  = 5'b00100,
    SER_PAR   = 5'b01000,
    SER_STOP  = 5'b10000
  } ulc_ser_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } ulc_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rd;
    logic [15:0] div;
    logic [7:0]  lctl;
    logic [3:0]  ien;
    logic [4:0]  mctl;
    logic [7:0]  scr;
    logic [15:0] bcnt;
    logic        tick;
    ulc_ser_type txs;
    logic [5:0]  txc;
    logic [2:0]  txb;
    logic [7:0]  txsh;
    logic        txp;
    logic [7:0]  thr;
    logic        thr_full;
    logic        txo;
    logic        serial_output;
    logic        iro;
    logic [1:0]  rsync;
    logic        rprev;
    ulc_ser_type rxs;
    logic [5:0]  rxc;
    logic [2:0]  rxb;
    logic [7:0]  rxsh;
    logic        rxp;
    logic        rpe;
    logic        rfe;
    logic        rzero;
    logic [7:0]  receive_buffer;
    logic        dr;
    logic        oe;
    logic        pe;
    logic        fe;
    logic        sb;
    logic [3:0]  evs;
    logic        irq;
  } ulc_regs_type;
endpackage

// ---- test/ulc_far_end.sv ----
// Purpose: Remote serial device model facing the line-control block.
// Assumes: One clock, bit time of BIT_CLKS clocks, line idle high.
// Notes:   Captures each frame bit-by-bit and times start-to-start gaps.
`timescale 1ns/1ps
`default_nettype none

module ulc_far_end #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic        clock_i,      // Shared clock
  input  wire logic        line_i,       // Serial line from the block
  input  wire logic [3:0]  frame_bits_i, // Bits to capture, start through first stop
  output logic             line_o,       // Serial line into the block
  output logic [11:0]      cap_o,        // Captured frame, start bit at bit 0
  output var int           gap_o         // Clocks between the last two starts
);
  int t_now   = 0;
  int t_start = 0;

  always @(posedge clock_i)
  begin
    t_now <= t_now + 1;
  end

  // ------------------------------------------------------------
  // Receive side: sample each bit in its middle
  // ------------------------------------------------------------
  initial
  begin
    line_o = 1'b1;
    cap_o  = '0;
    gap_o  = 0;
    forever
    begin
      @(negedge line_i);
      gap_o   = t_now - t_start;
      t_start = t_now;
      cap_o   = '0;
      repeat (BIT_CLKS / 2) @(posedge clock_i);
      for (int i = 0; i < frame_bits_i; i++)
      begin
        cap_o[i] = line_i;
        if (i + 1 < frame_bits_i)
          repeat (BIT_CLKS) @(posedge clock_i);
      end
    end
  end

  // ------------------------------------------------------------
  // Send side: called right after a rising edge
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pbit,
                      input int stop_clks);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clock_i);
    for (int i = 0; i < n; i++)
    begin
      line_o <= d[i];
      repeat (BIT_CLKS) @(posedge clock_i);
    end
    if (pen)
    begin
      line_o <= pbit;
      repeat (BIT_CLKS) @(posedge clock_i);
    end
    line_o <= 1'b1;
    repeat (stop_clks) @(posedge clock_i);
  endtask
endmodule

`default_nettype wire

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the line-control serial block.
// Assumes: Divisor 1, so one bit lasts 16 clocks.
// Notes:   Registers are reached through classic Wishbone single cycles.
`timescale 1ns/1ps
`default_nettype none
`include "ulc_params.svh"

module tb
  import ulc_pkg::*;
;
  logic           clock_i   = 1'b0;
  logic           reset_n_i = 1'b0;
  ulc_wb_req_type req       = '0;
  logic           wb_ack, so, ir, irq, rx_line, rts_n, dtr_n;
  logic [31:0]    wb_dat;
  logic [3:0]     fbits     = 4'hA;
  logic [11:0]    cap;
  logic [7:0]     q;
  int             gap, n_fail = 0, samples_checked = 0, cycles = 0;
  logic           mon_on    = 1'b0;
  int             ir_zero, so_zero, mon_cnt;
  logic [7:0]     cfg [8]   = '{8'h03, 8'h00, 8'h04, 8'h0F, 8'h1A, 8'h29, 8'h3B, 8'h45};
  logic [7:0]     rlc [5]   = '{8'h1B, 8'h1B, 8'h3B, 8'h3B, 8'h00};
  logic [7:0]     rdt [5]   = '{8'h5A, 8'h5A, 8'hFF, 8'hFF, 8'h15};
  logic           rpb [5]   = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic           rpe [5]   = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  always #10 clock_i = ~clock_i;

  ulc_uart u_dut (
    .clock_i                    (clock_i),
    .reset_n_i                  (reset_n_i),
    .wb_req_i                   (req),
    .wb_ack_o                   (wb_ack),
    .wb_dat_o                   (wb_dat),
    .serial_input_i             (rx_line),
    .serial_output_o            (so),
    .infrared_transmit_output_o (ir),
    .rts_n_o                    (rts_n),
    .dtr_n_o                    (dtr_n),
    .irq_o                      (irq)
  );

  ulc_far_end #(.BIT_CLKS(16)) u_far (
    .clock_i      (clock_i),
    .line_i       (so),
    .frame_bits_i (fbits),
    .line_o       (rx_line),
    .cap_o        (cap),
    .gap_o        (gap)
  );

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // Start-to-start spacing may slip by up to two ticks of baud-generator phase.
  task automatic chk_gap(input int got, input int exp);
    samples_checked++;
    if (got < exp || got > exp + 2)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  always @(posedge clock_i)
  begin
    cycles++;
    if (mon_on)
    begin
      mon_cnt++;
      ir_zero += (ir === 1'b0);
      so_zero += (so === 1'b0);
    end
    if (cycles == 60000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ------------------------------------------------------------
  // Bus access
  // ------------------------------------------------------------
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'h1, dat: {24'h000000, d}};
    do
    begin
      @(posedge clock_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    if (n >= 40)
      n_fail++;
    r = wb_dat[7:0];
    req <= '0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    bus(a, 1'b0, 8'h00, r);
  endtask

  task automatic wait_set(input logic [3:0] a, input logic [7:0] m);
    logic [7:0] r;
    int n;
    n = 0;
    r = 8'h00;
    while ((r & m) === 8'h00 && n < 300)
    begin
      rd(a, r);
      n++;
    end
    if (n >= 300)
      n_fail++;
  endtask

  function automatic logic [11:0] frame(input logic [7:0] lc, input logic [7:0] d);
    int n;
    logic [11:0] f;
    logic [7:0] dm;
    n = 5 + lc[1:0];
    dm = d & ((8'h01 << n) - 8'h01);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++)
      f[i + 1] = d[i];
    if (lc[3])
      f[n + 1] = lc[5] ? ~lc[4] : (^dm ^ ~lc[4]);
    return f & ((12'h001 << (n + 2 + lc[3])) - 12'h001);
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    wr(`ULC_IDX_LCTL, 8'h80);
    wr(`ULC_IDX_BUF, 8'h34);
    wr(`ULC_IDX_IEN, 8'h12);
    rd(`ULC_IDX_BUF, q);   chk(q, 8'h34);
    rd(`ULC_IDX_IEN, q);   chk(q, 8'h12);
    wr(`ULC_IDX_IEN, 8'h00);
    wr(`ULC_IDX_BUF, 8'h03);
    rd(`ULC_IDX_BUF, q);   chk(q, 8'h03);
    repeat (6) @(posedge clock_i);
    wr(`ULC_IDX_BUF, 8'h01);
    rd(`ULC_IDX_LCTL, q);  chk(q, 8'h80);
    wr(`ULC_IDX_LCTL, 8'h03);
    wr(`ULC_IDX_IEN, 8'hFF);
    rd(`ULC_IDX_IEN, q);   chk(q, 8'h0F);
    rd(`ULC_IDX_IID, q);   chk(q & 8'hC8, 8'h00);
    rd(`ULC_IDX_LSTAT, q); chk(q & 8'h80, 8'h00);
    wr(`ULC_IDX_SCR, 8'hA5);
    rd(`ULC_IDX_SCR, q);   chk(q, 8'hA5);
    rd(4'hA, q);           chk(q, 8'h00);
    // Loopback parks the modem outputs inactive and mirrors the controls.
    wr(`ULC_IDX_MCTL, 8'h1A);
    chk({rts_n, dtr_n}, 2'b11);
    rd(`ULC_IDX_MSTAT, q); chk(q, 8'h90);
    wr(`ULC_IDX_MCTL, 8'h03);
    chk({rts_n, dtr_n}, 2'b00);
    rd(`ULC_IDX_MSTAT, q); chk(q, 8'h00);
    rd(`ULC_IDX_MCTL, q);  chk(q, 8'h03);
    wr(`ULC_IDX_MCTL, 8'h00);
    chk({rts_n, dtr_n}, 2'b11);
    for (int k = 0; k < 8; k++)
    begin
      wr(`ULC_IDX_LCTL, cfg[k]);
      fbits <= 4'(7 + cfg[k][1:0] + cfg[k][3]);
      mon_on = 1'b0;
      @(posedge clock_i);
      ir_zero = 0;
      so_zero = 0;
      mon_cnt = 0;
      mon_on = 1'b1;
      wr(`ULC_IDX_BUF, 8'hC3 ^ 8'(k));
      wait_set(`ULC_IDX_LSTAT, 8'h20);
      wr(`ULC_IDX_BUF, 8'h96 + 8'(k * 17));
      wait_set(`ULC_IDX_LSTAT, 8'h40);
      chk(cap, frame(cfg[k], 8'h96 + 8'(k * 17)));
      chk_gap(gap, 16 * (6 + cfg[k][1:0] + cfg[k][3])
              + (cfg[k][2] ? (cfg[k][1:0] == 2'b00 ? 24 : 32) : 16));
      chk(ir_zero, cfg[k][6] ? mon_cnt : so_zero);
    end
    wr(`ULC_IDX_EVCLR, 8'h0F);
    wr(`ULC_IDX_IEN, 8'h01);
    chk(irq, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      wr(`ULC_IDX_LCTL, rlc[k]);
      u_far.send(rdt[k], 5 + rlc[k][1:0], rlc[k][3], rpb[k], 16);
      wait_set(`ULC_IDX_EVSTAT, 8'h01);
      if (k == 0)
      begin
        chk(irq, 1'b1);
        wr(`ULC_IDX_IEN, 8'h00);
        chk(irq, 1'b0);
        wr(`ULC_IDX_IEN, 8'h01);
        chk(irq, 1'b1);
      end
      wr(`ULC_IDX_EVCLR, 8'h01);
      chk(irq, 1'b0);
      rd(`ULC_IDX_EVSTAT, q); chk(q & 8'h01, 8'h00);
      rd(`ULC_IDX_BUF, q);    chk(q, rdt[k]);
      rd(`ULC_IDX_LSTAT, q);  chk(q & 8'h04, {5'h00, rpe[k], 2'h0});
      rd(`ULC_IDX_LSTAT, q);  chk(q & 8'h04, 8'h00);
    end
    end_sim();
  end
endmodule

`default_nettype wire
